// >>> design/dpr_pkg.sv
// shared constants and types for the configurable dual-port ram block
package dpr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses on the apb bus)
  localparam int          APB_AW     = 12;
  localparam logic [11:0] CTRL_OFF   = 12'h000; // configuration word
  localparam logic [11:0] STATUS_OFF = 12'h004; // derived block geometry

  ////////////////////////////////////////////////////////////////////////////
  // control word fields
  localparam int CTRL_MODE_BIT  = 0;  // port arrangement
  localparam int CTRL_DEPTH_LSB = 1;  // 3-bit max block depth code
  localparam int CTRL_CLK_LSB   = 4;  // 2-bit clocking scheme
  localparam int CTRL_RDEN_BIT  = 6;  // read enables in use
  localparam int CTRL_BE_BIT    = 7;  // byte enables in use
  localparam int CTRL_REGWR_BIT = 8;  // register write inputs
  localparam int CTRL_REGRD_BIT = 9;  // register read inputs
  localparam int CTRL_REGQ_BIT  = 10; // register read data outputs

  localparam logic [31:0] CTRL_MASK  = 32'h0000_07ff; // writable bits
  localparam logic [31:0] CTRL_RESET = 32'h0000_0300; // inputs registered

  ////////////////////////////////////////////////////////////////////////////
  // status word fields
  localparam int STATUS_BLK_LSB   = 0;  // physical blocks used
  localparam int STATUS_DEPTH_LSB = 16; // effective block depth in words

  ////////////////////////////////////////////////////////////////////////////
  // depth codes: 0 is automatic, n selects DEPTH_MIN << (n-1)
  localparam logic [2:0] DEPTH_CODE_AUTO = 3'h0;
  localparam int         DEPTH_MIN_LOG2  = 7; // 128 words

  // clocking schemes, gray coded
  typedef enum logic [1:0] {
    DPR_CLK_SINGLE = 2'b00,
    DPR_CLK_INOUT  = 2'b01,
    DPR_CLK_RDWR   = 2'b11,
    DPR_CLK_PORTS  = 2'b10
  } dpr_clk_t;

  // port arrangement
  typedef enum logic {
    DPR_SIMPLE = 1'b0,
    DPR_BIDIR  = 1'b1
  } dpr_mode_t;

endpackage

// >>> design/dpr_apb_regs.sv
// apb slave holding the control word and returning the status word
`timescale 1ns/100ps
module dpr_apb_regs (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic [dpr_pkg::APB_AW-1:0] paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [31:0]               status,
  output logic      [31:0]               ctrl
);

  logic [31:0] ctrl_ff;   // configuration word
  logic [31:0] nxt_ctrl;
  logic [31:0] rdata_ff;  // read data, loaded in the setup cycle
  logic [31:0] nxt_rdata;
  logic        hitCtrl;   // address decodes
  logic        hitStat;

  ////////////////////////////////////////////////////////////////////////////
  // decode and next values
  always_comb begin
    hitCtrl   = (paddr == dpr_pkg::CTRL_OFF);
    hitStat   = (paddr == dpr_pkg::STATUS_OFF);
    nxt_ctrl  = ctrl_ff;
    nxt_rdata = rdata_ff;
    // a write takes effect only in the access cycle
    if (psel && penable && pwrite && hitCtrl) begin
      nxt_ctrl = pwdata & dpr_pkg::CTRL_MASK;
    end
    // setup cycle loads read data so no wait state is needed
    if (psel && !penable) begin
      if (hitCtrl) begin
        nxt_rdata = ctrl_ff;
      end else if (hitStat) begin
        nxt_rdata = status;
      end else begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  // registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_ff  <= dpr_pkg::CTRL_RESET;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
    end
  end

  // zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(hitCtrl | hitStat);
  assign prdata  = rdata_ff;
  assign ctrl    = ctrl_ff;

endmodule

// >>> design/dpr_port_stage.sv
// optional input register stage for one memory port
`timescale 1ns/100ps
module dpr_port_stage #(
  parameter int DW = 8,
  parameter int AW = 8,
  parameter int BW = 1
) (
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire logic          regIn,  // register data, address, write
  input  wire logic          regRd,  // register read enable
  input  wire logic          inEn,   // inbound tick of this port
  input  wire logic [DW-1:0] data,
  input  wire logic [AW-1:0] addr,
  input  wire logic          wren,
  input  wire logic [BW-1:0] be,
  input  wire logic          rden,
  output logic      [DW-1:0] dataO,
  output logic      [AW-1:0] addrO,
  output logic      [BW-1:0] beO,
  output logic               wrNow,  // write the core this cycle
  output logic               rdNow   // read the core this cycle
);

  logic [DW-1:0] data_ff;
  logic [AW-1:0] addr_ff;
  logic [BW-1:0] be_ff;
  logic          wren_ff;
  logic          rden_ff;
  logic [DW-1:0] nxt_data;
  logic [AW-1:0] nxt_addr;
  logic [BW-1:0] nxt_be;
  logic          nxt_wren;
  logic          nxt_rden;

  ////////////////////////////////////////////////////////////////////////////
  // capture only on this port's inbound tick
  always_comb begin
    nxt_data = inEn ? data : data_ff;
    nxt_addr = inEn ? addr : addr_ff;
    nxt_be   = inEn ? be   : be_ff;
    nxt_wren = inEn ? wren : wren_ff;
    nxt_rden = inEn ? rden : rden_ff;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      data_ff <= '0;
      addr_ff <= '0;
      be_ff   <= '0;
      wren_ff <= 1'b0;
      rden_ff <= 1'b0;
    end else begin
      data_ff <= nxt_data;
      addr_ff <= nxt_addr;
      be_ff   <= nxt_be;
      wren_ff <= nxt_wren;
      rden_ff <= nxt_rden;
    end
  end

  // bypass or registered view; a registered request acts one tick later
  assign dataO = regIn ? data_ff : data;
  assign addrO = regIn ? addr_ff : addr;
  assign beO   = regIn ? be_ff   : be;
  assign wrNow = inEn & (regIn ? wren_ff : wren);
  assign rdNow = inEn & (regRd ? rden_ff : rden);

endmodule

// >>> design/dpr_ram_top.sv
// configurable dual-port ram with clocking, enable and register options
// Contract
// RULE_01: simple write/read or two read/write ports
// RULE_02: max block depth auto or 128..8192
// RULE_03: single scheme: one tick, one enable
// RULE_04: inout scheme: input tick in, output tick out
// RULE_05: rdwr scheme: write tick drives write side
// RULE_06: rdwr scheme: read tick drives read side
// RULE_07: ports scheme: each port on own tick
// RULE_08: ports scheme: independent enable per port
// RULE_09: simple mode has one optional read enable
// RULE_10: bidir mode has read enable per port
// RULE_11: byte enables mask written lanes
// RULE_12: write in, read in, output registering selectable
// RULE_13: read disabled keeps last read data
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module dpr_ram_top #(
  parameter int DW         = 8,    // word width
  parameter int AW         = 8,    // address width
  parameter int BW         = 1,    // byte enable lanes
  parameter int AUTO_DEPTH = 8192  // depth chosen by the automatic setting
) (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // apb register port
  input  wire logic [dpr_pkg::APB_AW-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // scheme ticks and enables, all synchronous to mclk
  input  wire logic                       clkTickA,
  input  wire logic                       clkTickB,
  input  wire logic                       clkEnA,
  input  wire logic                       clkEnB,
  // port a: write port in simple mode
  input  wire logic [DW-1:0]              dataA,
  input  wire logic [AW-1:0]              addrA,
  input  wire logic                       wrenA,
  input  wire logic [BW-1:0]              byteEnA,
  input  wire logic                       rdenA,
  output logic      [DW-1:0]              qA,
  // port b: read port in simple mode
  input  wire logic [DW-1:0]              dataB,
  input  wire logic [AW-1:0]              addrB,
  input  wire logic                       wrenB,
  input  wire logic [BW-1:0]              byteEnB,
  input  wire logic                       rdenB,
  output logic      [DW-1:0]              qB
);

  localparam int WORDS     = 1 << AW;         // words in the core
  localparam int LANE      = DW / BW;         // bits per enable lane
  localparam int AUTO_LOG2 = $clog2(AUTO_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // expand lane enables into a bit mask
  function automatic logic [DW-1:0] laneMask(input logic [BW-1:0] be);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < DW; i++) begin
      m[i] = be[i / LANE];
    end
    return m;
  endfunction

  // merge new data into an old word under a lane mask
  function automatic logic [DW-1:0] mergeWord(
    input logic [DW-1:0] oldW,
    input logic [DW-1:0] newW,
    input logic [BW-1:0] be
  );
    logic [DW-1:0] m;
    m = laneMask(be);
    return (oldW & ~m) | (newW & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // control word and its fields
  logic [31:0]       ctrl;       // configuration from software
  logic [31:0]       status;     // geometry shown to software
  dpr_pkg::dpr_mode_t mode;      // port arrangement
  dpr_pkg::dpr_clk_t  scheme;    // clocking scheme
  logic [2:0]        depthCode;  // max block depth code
  logic              useRden;    // read enables honoured
  logic              useBe;      // byte enables honoured
  logic              regWr;      // write inputs registered
  logic              regRd;      // read inputs registered
  logic              regQ;       // outputs registered

  dpr_apb_regs u_regs (
    .mclk    (mclk),
    .reset   (reset),
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .status  (status),
    .ctrl    (ctrl)
  );

  // field extraction
  always_comb begin
    mode      = dpr_pkg::dpr_mode_t'(ctrl[dpr_pkg::CTRL_MODE_BIT]); // RULE_01
    scheme    = dpr_pkg::dpr_clk_t'(ctrl[dpr_pkg::CTRL_CLK_LSB +: 2]);
    depthCode = ctrl[dpr_pkg::CTRL_DEPTH_LSB +: 3];
    useRden   = ctrl[dpr_pkg::CTRL_RDEN_BIT];
    useBe     = ctrl[dpr_pkg::CTRL_BE_BIT];
    regWr     = ctrl[dpr_pkg::CTRL_REGWR_BIT]; // RULE_12
    regRd     = ctrl[dpr_pkg::CTRL_REGRD_BIT]; // RULE_12
    regQ      = ctrl[dpr_pkg::CTRL_REGQ_BIT];  // RULE_12
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock domain ticks
  // each scheme clock is a tick strobe on mclk; a register of a domain
  // advances only when that domain ticks and its enable is high
  logic tickA;  // tick a gated by its enable
  logic tickB;  // tick b gated by its enable
  logic inA;    // inbound tick, port a
  logic inB;    // inbound tick, port b
  logic outA;   // outbound tick, port a
  logic outB;   // outbound tick, port b

  always_comb begin
    tickA = clkTickA & clkEnA;
    tickB = clkTickB & clkEnB; // RULE_08
    unique case (scheme)
      dpr_pkg::DPR_CLK_SINGLE: begin
        // one tick and one enable for everything
        inA  = tickA; // RULE_03
        inB  = tickA; // RULE_03
        outA = tickA; // RULE_03
        outB = tickA; // RULE_03
      end
      dpr_pkg::DPR_CLK_INOUT: begin
        // tick a for all inbound, tick b for outbound data
        inA  = tickA; // RULE_04
        inB  = tickA; // RULE_04
        outA = tickB; // RULE_04
        outB = tickB; // RULE_04
      end
      dpr_pkg::DPR_CLK_RDWR: begin
        // write side on a, read side on b; in bidir mode
        // this behaves as the per-port scheme
        inA  = tickA; // RULE_05
        outA = tickA; // RULE_05
        inB  = tickB; // RULE_06
        outB = tickB; // RULE_06
      end
      dpr_pkg::DPR_CLK_PORTS: begin
        // every port a register on a, every port b register on b
        inA  = tickA; // RULE_07
        outA = tickA; // RULE_07
        inB  = tickB; // RULE_07
        outB = tickB; // RULE_07
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // request shaping per port
  logic          rdReqA;   // read request, port a
  logic          rdReqB;   // read request, port b
  logic          wrReqB;   // write request, port b
  logic [BW-1:0] beLiveA;  // effective lane enables, port a
  logic [BW-1:0] beLiveB;  // effective lane enables, port b
  logic          regInB;   // input registering for port b

  always_comb begin
    // without read enables every tick reads, except on port a in simple mode
    rdReqA = (mode == dpr_pkg::DPR_BIDIR) && (!useRden || rdenA); // RULE_10
    if (mode == dpr_pkg::DPR_BIDIR) begin
      rdReqB = !useRden || rdenB; // RULE_10
      wrReqB = wrenB;
      regInB = regWr;
    end else begin
      // single read enable of the read port
      rdReqB = !useRden || rdenB; // RULE_09
      wrReqB = 1'b0;
      regInB = regRd;
    end
    // unused byte enables mean whole-word writes
    beLiveA = useBe ? byteEnA : {BW{1'b1}}; // RULE_11
    beLiveB = useBe ? byteEnB : {BW{1'b1}}; // RULE_11
  end

  logic [DW-1:0] dataSA;
  logic [AW-1:0] addrSA;
  logic [BW-1:0] beSA;
  logic          wrNowA;
  logic          rdNowA;
  logic [DW-1:0] dataSB;
  logic [AW-1:0] addrSB;
  logic [BW-1:0] beSB;
  logic          wrNowB;
  logic          rdNowB;

  // port a stage: the write inputs of simple mode
  dpr_port_stage #(.DW(DW), .AW(AW), .BW(BW)) u_stageA (
    .mclk  (mclk),
    .reset (reset),
    .regIn (regWr),
    .regRd (regRd),
    .inEn  (inA),
    .data  (dataA),
    .addr  (addrA),
    .wren  (wrenA),
    .be    (beLiveA),
    .rden  (rdReqA),
    .dataO (dataSA),
    .addrO (addrSA),
    .beO   (beSA),
    .wrNow (wrNowA),
    .rdNow (rdNowA)
  );

  // port b stage: the read inputs of simple mode
  dpr_port_stage #(.DW(DW), .AW(AW), .BW(BW)) u_stageB (
    .mclk  (mclk),
    .reset (reset),
    .regIn (regInB),
    .regRd (regRd),
    .inEn  (inB),
    .data  (dataB),
    .addr  (addrB),
    .wren  (wrReqB),
    .be    (beLiveB),
    .rden  (rdReqB),
    .dataO (dataSB),
    .addrO (addrSB),
    .beO   (beSB),
    .wrNow (wrNowB),
    .rdNow (rdNowB)
  );

  ////////////////////////////////////////////////////////////////////////////
  // storage core
  // no reset on the array: contents are undefined until written,
  // which keeps the core mappable onto plain block memory
  logic [DW-1:0] mem [WORDS];
  logic [DW-1:0] memA;  // word at port a address
  logic [DW-1:0] memB;  // word at port b address

  assign memA = mem[addrSA];
  assign memB = mem[addrSB];

  // two writes to one address in one cycle: port b lands last
  always_ff @(posedge mclk) begin
    if (wrNowA) begin
      mem[addrSA] <= mergeWord(memA, dataSA, beSA); // RULE_11
    end
    if (wrNowB) begin
      mem[addrSB] <= mergeWord(memB, dataSB, beSB); // RULE_11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read paths
  // the latch is the core read register on the inbound tick; the
  // optional output register adds one outbound tick of latency
  logic [DW-1:0] rdLatA_ff;
  logic [DW-1:0] rdLatB_ff;
  logic [DW-1:0] qRegA_ff;
  logic [DW-1:0] qRegB_ff;
  logic [DW-1:0] nxt_rdLatA;
  logic [DW-1:0] nxt_rdLatB;
  logic [DW-1:0] nxt_qRegA;
  logic [DW-1:0] nxt_qRegB;

  always_comb begin
    // read before write: a same-cycle write is not yet visible
    nxt_rdLatA = rdNowA ? memA : rdLatA_ff; // RULE_13
    nxt_rdLatB = rdNowB ? memB : rdLatB_ff; // RULE_13
    nxt_qRegA  = outA ? rdLatA_ff : qRegA_ff;
    nxt_qRegB  = outB ? rdLatB_ff : qRegB_ff;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rdLatA_ff <= '0;
      rdLatB_ff <= '0;
      qRegA_ff  <= '0;
      qRegB_ff  <= '0;
    end else begin
      rdLatA_ff <= nxt_rdLatA;
      rdLatB_ff <= nxt_rdLatB;
      qRegA_ff  <= nxt_qRegA;
      qRegB_ff  <= nxt_qRegB;
    end
  end

  // output select; port a never reads in simple mode
  always_comb begin
    qB = regQ ? qRegB_ff : rdLatB_ff; // RULE_12
    if (mode == dpr_pkg::DPR_BIDIR) begin
      qA = regQ ? qRegA_ff : rdLatA_ff; // RULE_12
    end else begin
      qA = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // block geometry
  // all depths are powers of two, so the block count is a shift
  logic [4:0]  depthLog2;  // log2 of the effective block depth
  logic [15:0] depthWords; // effective block depth in words
  logic [15:0] blocks;     // physical blocks to cover the core
  logic [31:0] status_ff;
  logic [31:0] nxt_status;

  always_comb begin
    if (depthCode == dpr_pkg::DEPTH_CODE_AUTO) begin
      depthLog2 = 5'(AUTO_LOG2); // RULE_02
    end else begin
      depthLog2 = 5'(dpr_pkg::DEPTH_MIN_LOG2 - 1 + int'(depthCode)); // RULE_02
    end
    depthWords = 16'(32'h1 << depthLog2);
    if (AW > int'(depthLog2)) begin
      blocks = 16'(32'h1 << (AW - int'(depthLog2)));
    end else begin
      blocks = 16'h0001;
    end
    nxt_status = '0;
    nxt_status[dpr_pkg::STATUS_BLK_LSB +: 16]   = blocks;
    nxt_status[dpr_pkg::STATUS_DEPTH_LSB +: 16] = depthWords;
  end

  // registered so the slave sees a stable word
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_ff <= '0;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign status = status_ff;

endmodule

// >>> dv/dpr_ram_monitor.sv
// port checker bound into the ram block
`timescale 1ns/100ps
module dpr_ram_monitor #(
  parameter int DW         = 8,
  parameter int AW         = 8,
  parameter int AUTO_DEPTH = 8192
) (
  input wire logic          mclk,
  input wire logic          reset,
  input wire logic [11:0]   paddr,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          clkTickA,
  input wire logic          clkTickB,
  input wire logic          clkEnA,
  input wire logic          clkEnB,
  input wire logic          rdenB,
  input wire logic [DW-1:0] qA,
  input wire logic [DW-1:0] qB
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  // shadow control word, so holds know the scheme
  logic [10:0] ctrl_ff;  // shadow control word
  logic [10:0] nxt_ctrl;
  logic        acc;      // apb access phase
  logic [1:0]  sch;      // clocking scheme field
  int          depW;     // expected block depth
  int          blkW;     // expected block count
  always_comb begin
    acc      = psel && penable;
    nxt_ctrl = (acc && pwrite && paddr == dpr_pkg::CTRL_OFF) ? pwdata[10:0] : ctrl_ff;
    sch      = ctrl_ff[5:4];
    depW     = (ctrl_ff[3:1] == 3'h0) ? AUTO_DEPTH : 128 << (ctrl_ff[3:1] - 3'h1);
    blkW     = ((1 << AW) > depW) ? (1 << AW) / depW : 1;
  end
  // whole-word writes only, all the bus offers
  always_ff @(posedge mclk) begin
    if (reset) ctrl_ff <= 11'h300;
    else ctrl_ff <= nxt_ctrl;
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus answers
  zero_wait_a: assert property (acc |-> pready) else $error("access not ready");
  unmapped_err_a: assert property (acc && paddr[11:3] != 9'h0 |-> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  ctrl_readback_a: assert property (acc && !pwrite && paddr == dpr_pkg::CTRL_OFF
    |-> prdata == {21'h0, ctrl_ff}) else $error("ctrl readback wrong");
  status_geom_a: assert property (acc && !pwrite && paddr == dpr_pkg::STATUS_OFF
    |-> prdata == {depW[15:0], blkW[15:0]}) else $error("status geometry wrong");
  ////////////////////////////////////////////////////////////////////////////
  // an idle tick holds q; three cycles let a registered request drain
  qa_idle_a: assert property ((!ctrl_ff[0]) [*3] |-> qA == '0)
    else $error("qA not idle");
  single_hold_a: assert property ((sch == 2'h0 && !(clkTickA && clkEnA)) [*3]
    |=> $stable(qB)) else $error("qB moved, single idle");
  inout_hold_a: assert property ((sch == 2'h1 && ctrl_ff[10] && !(clkTickB && clkEnB)) [*3]
    |=> $stable(qB)) else $error("qB moved, out idle");
  rdwr_hold_a: assert property ((sch == 2'h3 && !(clkTickB && clkEnB)) [*3]
    |=> $stable(qB)) else $error("qB moved, read idle");
  porta_hold_a: assert property ((sch == 2'h2 && ctrl_ff[0] && !(clkTickA && clkEnA)) [*3]
    |=> $stable(qA)) else $error("qA moved, a idle");
  rden_hold_a: assert property ((sch == 2'h0 && ctrl_ff[6] && !rdenB) [*3]
    |=> $stable(qB)) else $error("qB moved, rden low");
  cover property (acc && pwrite && paddr == dpr_pkg::CTRL_OFF);
  cover property (sch == 2'h2 && ctrl_ff[0] && !clkEnA);
  cover property (ctrl_ff[6] && !rdenB);
endmodule

bind dpr_ram_top dpr_ram_monitor #(.DW(DW), .AW(AW), .AUTO_DEPTH(AUTO_DEPTH)) u_mon (.*);

// >>> dv/dpr_user_model.sv
// user logic model driving both ports and the ticks
`timescale 1ns/100ps
module dpr_user_model #(
  parameter int DW = 16,
  parameter int AW = 8,
  parameter int BW = 2
) (
  input  wire logic     mclk,
  output logic          clkTickA,
  output logic          clkTickB,
  output logic          clkEnA,
  output logic          clkEnB,
  output logic [DW-1:0] dataA,
  output logic [AW-1:0] addrA,
  output logic          wrenA,
  output logic [BW-1:0] byteEnA,
  output logic          rdenA,
  output logic [DW-1:0] dataB,
  output logic [AW-1:0] addrB,
  output logic          wrenB,
  output logic [BW-1:0] byteEnB,
  output logic          rdenB
);
  // ticks running, ports quiet
  initial begin
    {clkTickA, clkTickB, clkEnA, clkEnB} = 4'hf;
    {wrenA, wrenB, rdenA, rdenB} = 4'h0;
    {dataA, dataB, addrA, addrB, byteEnA, byteEnB} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // ticks and enables as {tickA, tickB, enA, enB}
  task automatic tk(input logic [3:0] t);
    @(posedge mclk);
    {clkTickA, clkTickB, clkEnA, clkEnB} <= t;
  endtask
  // one-cycle write; released data flips so a stale sample shows up
  task automatic wr(input logic p, input logic [AW-1:0] a, input logic [DW-1:0] d,
                    input logic [BW-1:0] b);
    @(posedge mclk);
    if (p) begin
      {wrenB, addrB, dataB, byteEnB} <= {1'h1, a, d, b};
    end else begin
      {wrenA, addrA, dataA, byteEnA} <= {1'h1, a, d, b};
    end
    @(posedge mclk);
    wrenA <= 1'h0;
    wrenB <= 1'h0;
    if (p) dataB <= ~d;
    else dataA <= ~d;
  endtask
  // read request stands until the next one
  task automatic rd(input logic p, input logic [AW-1:0] a, input logic r);
    @(posedge mclk);
    if (p) {addrB, rdenB} <= {a, r};
    else {addrA, rdenA} <= {a, r};
  endtask
endmodule

// >>> dv/tb.sv
// self-checking bench for the dual-port ram
`timescale 1ns/100ps
module tb;
  logic        mclk, reset, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        clkTickA, clkTickB, clkEnA, clkEnB, wrenA, wrenB, rdenA, rdenB;
  logic [15:0] dataA, dataB, qA, qB;
  logic [7:0]  addrA, addrB;
  logic [1:0]  byteEnA, byteEnB;
  int          n_fail = 0, n_tests = 0, cyc = 0, dep, blk;
  dpr_ram_top #(.DW(16), .AW(8), .BW(2)) u_dut (.*);
  dpr_user_model u_user (.*);
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  // a hang is a mismatch; the run needs under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
    n_tests++;
    if (seen !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, seen);
    end
  endtask
  // apb transfer; answer taken at the edge pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic setc(input logic [31:0] v);
    apb(1'h1, dpr_pkg::CTRL_OFF, v);
  endtask
  // four edges cover registered inputs and output
  task automatic qchk(input logic p, input logic [15:0] x, input string nm);
    repeat (4) @(posedge mclk);
    #1;
    chk(nm, {16'h0, p ? qB : qA}, {16'h0, x});
  endtask
  task automatic rq(input logic p, input logic [7:0] a, input logic rd, input logic [15:0] x,
                    input string nm);
    u_user.rd(p, a, rd);
    qchk(p, x, nm);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset = 1'h1;
    repeat (6) @(posedge mclk);
    reset <= 1'h0;
    apb(1'h0, dpr_pkg::CTRL_OFF, 32'h0);
    chk("ctrl reset", r, dpr_pkg::CTRL_RESET);
    setc(32'hffff_ffff);
    apb(1'h0, dpr_pkg::CTRL_OFF, 32'h0);
    chk("ctrl mask", r, dpr_pkg::CTRL_MASK);
    apb(1'h0, 12'h008, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    apb(1'h1, dpr_pkg::STATUS_OFF, 32'h0);
    $display("test registers done");
    // every depth code over a 256-word array
    for (int c = 0; c < 8; c++) begin
      setc(32'(c) << 1);
      apb(1'h0, dpr_pkg::STATUS_OFF, 32'h0);
      dep = (c == 0) ? 8192 : 128 << (c - 1);
      blk = (dep < 256) ? 256 / dep : 1;
      chk("status", r, {dep[15:0], blk[15:0]});
    end
    $display("test depth done");
    setc(32'h0);
    u_user.wr(1'h0, 8'h05, 16'haaaa, 2'h3);
    rq(1'h1, 8'h05, 1'h1, 16'haaaa, "simple read");
    chk("qA idle", {16'h0, qA}, 32'h0);
    setc(32'h080);
    u_user.wr(1'h0, 8'h05, 16'h5555, 2'h1);
    rq(1'h1, 8'h05, 1'h1, 16'haa55, "lane mask");
    setc(32'h0);
    u_user.wr(1'h0, 8'h05, 16'h1234, 2'h0);
    rq(1'h1, 8'h05, 1'h1, 16'h1234, "lanes unused");
    u_user.wr(1'h0, 8'h07, 16'h1111, 2'h3);
    u_user.tk(4'hd);
    u_user.wr(1'h0, 8'h07, 16'h2222, 2'h3);
    u_user.tk(4'hf);
    rq(1'h1, 8'h07, 1'h1, 16'h1111, "enable off");
    $display("test single done");
    setc(32'h040);
    rq(1'h1, 8'h05, 1'h1, 16'h1234, "rden on");
    rq(1'h1, 8'h07, 1'h0, 16'h1234, "rden hold");
    setc(32'h740);
    u_user.wr(1'h0, 8'h09, 16'h0f0f, 2'h3);
    rq(1'h1, 8'h09, 1'h1, 16'h0f0f, "all registered");
    $display("test enables done");
    setc(32'h410);
    u_user.tk(4'hb);
    rq(1'h1, 8'h07, 1'h1, 16'h0f0f, "out tick off");
    u_user.tk(4'hf);
    qchk(1'h1, 16'h1111, "out tick on");
    setc(32'h030);
    u_user.tk(4'h7);
    u_user.wr(1'h0, 8'h07, 16'h3333, 2'h3);
    u_user.tk(4'hf);
    rq(1'h1, 8'h07, 1'h1, 16'h1111, "write tick off");
    u_user.tk(4'hb);
    rq(1'h1, 8'h05, 1'h1, 16'h1111, "read tick off");
    u_user.tk(4'hf);
    $display("test dual clock done");
    setc(32'h021);
    u_user.wr(1'h1, 8'h08, 16'h4444, 2'h3);
    rq(1'h0, 8'h08, 1'h1, 16'h4444, "port b write");
    u_user.tk(4'he);
    u_user.wr(1'h1, 8'h08, 16'h5555, 2'h3);
    u_user.tk(4'h7);
    u_user.rd(1'h0, 8'h05, 1'h1);
    rq(1'h1, 8'h08, 1'h1, 16'h4444, "port b enable");
    qchk(1'h0, 16'h4444, "port a held");
    u_user.tk(4'hf);
    setc(32'h061);
    rq(1'h0, 8'h07, 1'h0, 16'h1234, "rden a hold");
    rq(1'h1, 8'h07, 1'h0, 16'h4444, "rden b hold");
    rq(1'h0, 8'h07, 1'h1, 16'h1111, "rden a on");
    $display("test ports done");
    wrap_up();
  end
endmodule
